// >>> hw/fpec_ctrl.sv
module fpec_ctrl #(
  parameter int WRITE_CYC = fpec_pkg::FPEC_WRITE_CYC,  // byte write length
  parameter int ERASE_CYC = fpec_pkg::FPEC_ERASE_CYC,  // page erase length
  parameter int MAIN_BYTES = fpec_pkg::FPEC_MAIN_BYTES  // main array size
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // external-data move port
  input wire fpec_pkg::fpec_xreq_t xreq_in,
  output logic external_data_ram_we_out,            // write strobe to data ram
  output logic external_data_ram_re_out,            // read strobe to data ram
  output logic [15:0] external_data_ram_addr_out,
  output logic [7:0] external_data_ram_wdata_out,
  // code-space read port
  input wire fpec_pkg::fpec_creq_t creq_in,
  output logic [7:0] crdata_out,       // code byte read data
  output logic crvalid_out,            // read data valid pulse
  output logic stall_out,              // stall core fetch
  // interrupt gating
  input wire logic irq_pending_in,     // an interrupt is pending
  input wire logic irq_cached_in,      // its handler is in cache
  input wire logic exec_cached_in,     // core running from cache now
  output logic irq_allow_out,          // interrupt may be taken now
  output logic nvm_busy_flag_out
);
  // ****************************************************************
  // control registers
  // ****************************************************************
  logic store_write_enable_reg;        // redirect writes to flash
  logic store_erase_enable_reg;        // writes become erases
  logic scratchpad_access_enable_reg;  // overlay scratchpad
  logic nvm_write_enable_reg;          // global write/erase enable
  logic [1:0] upper_bank_select_reg;   // bank in upper window
  logic nvm_busy_flag_reg;             // operation in progress

  logic apb_wr;                        // write access phase
  logic addr_ok;                       // address mapped

  // ****************************************************************
  // storage arrays
  // ****************************************************************
  logic [7:0] main_mem [MAIN_BYTES];                   // main flash
  logic [7:0] scr_mem [fpec_pkg::FPEC_SCR_BYTES];      // scratchpad flash

  assign apb_wr = psel_in && penable_in && pwrite_in;
  // zero wait states: every access ends in its first access cycle
  assign pready_out = 1'b1;
  assign addr_ok = (paddr_in == fpec_pkg::FPEC_ADDR_CTRL) ||
                   (paddr_in == fpec_pkg::FPEC_ADDR_BANK) ||
                   (paddr_in == fpec_pkg::FPEC_ADDR_STAT) ||
                   (paddr_in == fpec_pkg::FPEC_ADDR_NVM_WRITE_ENABLE);
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  // program_store_control bits
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      store_write_enable_reg <= 1'b0;
      store_erase_enable_reg <= 1'b0;
      scratchpad_access_enable_reg <= 1'b0;
    end else if (apb_wr && paddr_in == fpec_pkg::FPEC_ADDR_CTRL) begin
      store_write_enable_reg <= pwdata_in[fpec_pkg::FPEC_CTRL_STORE_WRITE_ENABLE_BIT];
      store_erase_enable_reg <= pwdata_in[fpec_pkg::FPEC_CTRL_STORE_ERASE_ENABLE_BIT];
      scratchpad_access_enable_reg <= pwdata_in[fpec_pkg::FPEC_CTRL_SCRATCHPAD_ACCESS_ENABLE_BIT];
    end
  end

  // bank select register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      upper_bank_select_reg <= fpec_pkg::FPEC_BANK_RESET;
    end else if (apb_wr && paddr_in == fpec_pkg::FPEC_ADDR_BANK) begin
      upper_bank_select_reg <= pwdata_in[fpec_pkg::FPEC_BANK_LSB +: 2];
    end
  end

  // nvm write enable register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nvm_write_enable_reg <= 1'b0;
    end else if (apb_wr && paddr_in == fpec_pkg::FPEC_ADDR_NVM_WRITE_ENABLE) begin
      nvm_write_enable_reg <= pwdata_in[fpec_pkg::FPEC_NVM_WRITE_ENABLE_BIT];
    end
  end

  // apb read mux
  // loaded in the setup cycle so the data stands through the access phase
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      if (paddr_in == fpec_pkg::FPEC_ADDR_CTRL) begin
        prdata_out <= {29'h0, scratchpad_access_enable_reg,
                       store_erase_enable_reg, store_write_enable_reg};
      end else if (paddr_in == fpec_pkg::FPEC_ADDR_BANK) begin
        prdata_out <= {26'h0, upper_bank_select_reg, 4'h0};
      end else if (paddr_in == fpec_pkg::FPEC_ADDR_STAT) begin
        prdata_out <= {31'h0, nvm_busy_flag_reg};
      end else if (paddr_in == fpec_pkg::FPEC_ADDR_NVM_WRITE_ENABLE) begin
        prdata_out <= {31'h0, nvm_write_enable_reg};
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // address mapping
  // ****************************************************************
  // map a 16-bit core address to a flash byte address
  function automatic logic [16:0] map_addr(input logic [15:0] a, input logic [1:0] bank);
    logic [16:0] r;
    // lower half maps straight through to the fixed bank
    r = {1'b0, a};
    if (a[15]) begin
      r = {bank, a[14:0]};
    end
    return r;
  endfunction

  logic x_is_flash;      // data-move write aimed at flash
  logic x_scr;           // write falls in scratchpad overlay
  logic x_both;          // erase both scratchpad sectors
  logic [16:0] x_faddr;  // mapped flash address
  logic start_op;        // launch write or erase
  logic op_erase;        // launched op is an erase
  logic timer_done;      // operation finished
  fpec_pkg::fpec_op_t op_reg;
  logic [16:0] op_addr_reg;
  logic [7:0] op_data_reg;
  logic op_scr_reg;
  logic op_both_reg;

  assign x_is_flash = xreq_in.valid && xreq_in.write && store_write_enable_reg;
  assign x_scr = scratchpad_access_enable_reg && (xreq_in.addr[15:8] == 8'h00);
  assign x_both = scratchpad_access_enable_reg && store_erase_enable_reg &&
                  (xreq_in.addr == fpec_pkg::FPEC_BOTH_SECT_ADDR);
  assign x_faddr = map_addr(xreq_in.addr, upper_bank_select_reg);
  // moves arriving while busy or without the global enable are dropped
  assign start_op = x_is_flash && nvm_write_enable_reg && !nvm_busy_flag_reg;
  assign op_erase = store_erase_enable_reg;

  // data-ram side: writes when not redirected, every read
  // registered so the ram strobes stand one full cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      external_data_ram_we_out <= 1'b0;
      external_data_ram_re_out <= 1'b0;
      external_data_ram_addr_out <= 16'h0000;
      external_data_ram_wdata_out <= 8'h00;
    end else begin
      external_data_ram_we_out <= xreq_in.valid && xreq_in.write && !store_write_enable_reg;
      external_data_ram_re_out <= xreq_in.valid && !xreq_in.write;
      external_data_ram_addr_out <= xreq_in.addr;
      external_data_ram_wdata_out <= xreq_in.wdata;
    end
  end

  // latch the operation being timed
  // captured at launch so the core may drive new moves at once
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      op_reg <= fpec_pkg::FPEC_OP_IDLE;
      op_addr_reg <= 17'h00000;
      op_data_reg <= 8'h00;
      op_scr_reg <= 1'b0;
      op_both_reg <= 1'b0;
    end else if (start_op) begin
      op_reg <= op_erase ? fpec_pkg::FPEC_OP_ERASE : fpec_pkg::FPEC_OP_WRITE;
      op_addr_reg <= x_faddr;
      op_data_reg <= xreq_in.wdata;
      op_scr_reg <= x_scr;
      op_both_reg <= x_both;
    end else if (timer_done) begin
      op_reg <= fpec_pkg::FPEC_OP_IDLE;
    end
  end

  // hardware timed operation
  // length picked by op_erase as the start_op strobe loads the counter
  fpec_op_timer #(.CNT_W(32)) u_timer (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .start_in(start_op),
    .load_in(op_erase ? 32'(ERASE_CYC) : 32'(WRITE_CYC)),
    .busy_out(),
    .done_out(timer_done)
  );

  // busy flag
  // launch needs busy low, so set and clear never meet
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nvm_busy_flag_reg <= 1'b0;
    end else if (start_op) begin
      nvm_busy_flag_reg <= 1'b1;
    end else if (timer_done) begin
      nvm_busy_flag_reg <= 1'b0;
    end
  end
  assign nvm_busy_flag_out = nvm_busy_flag_reg;

  // ****************************************************************
  // array update at completion
  // ****************************************************************
  // arrays have no reset: software erases before it programs
  // separate scratchpad array kept alongside main
  always_ff @(posedge clk_in) begin
    if (timer_done && op_reg == fpec_pkg::FPEC_OP_WRITE) begin
      if (op_scr_reg) begin
        scr_mem[op_addr_reg[7:0]] <= scr_mem[op_addr_reg[7:0]] & op_data_reg;
      end else begin
        main_mem[op_addr_reg] <= main_mem[op_addr_reg] & op_data_reg;
      end
    end else if (timer_done && op_reg == fpec_pkg::FPEC_OP_ERASE) begin
      for (int i = 0; i < fpec_pkg::FPEC_SCR_BYTES; i++) begin
        if ((op_scr_reg && i[7] == op_addr_reg[7]) || op_both_reg) begin
          scr_mem[i] <= fpec_pkg::FPEC_ERASED;
        end
      end
      if (!op_scr_reg && !op_both_reg) begin
        for (int j = 0; j < (1 << fpec_pkg::FPEC_PAGE_BITS); j++) begin
          main_mem[{op_addr_reg[16:10], j[9:0]}] <= fpec_pkg::FPEC_ERASED;
        end
      end
    end
  end

  // ****************************************************************
  // code-space reads and stall
  // ****************************************************************
  logic c_scr;           // read served by scratchpad
  logic [16:0] c_faddr;  // mapped code address
  assign c_scr = scratchpad_access_enable_reg && !creq_in.is_fetch &&
                 (creq_in.addr[15:8] == 8'h00);
  assign c_faddr = map_addr(creq_in.addr, upper_bank_select_reg);
  // uncached flash access stalls while busy
  // cached fetches keep running from the prefetch buffer or cache
  assign stall_out = creq_in.valid && !creq_in.cached && nvm_busy_flag_reg;

  // flash read data only on code-space port
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      crdata_out <= 8'h00;
      crvalid_out <= 1'b0;
    end else begin
      crvalid_out <= creq_in.valid && !stall_out;
      if (creq_in.valid && !stall_out) begin
        crdata_out <= c_scr ? scr_mem[creq_in.addr[7:0]] : main_mem[c_faddr];
      end
    end
  end

  // cached handler while running from cache
  // others held until busy clears
  // a held interrupt stays pending in the core; none is lost here
  assign irq_allow_out = irq_pending_in &&
                         (!nvm_busy_flag_reg || (irq_cached_in && exec_cached_in));
endmodule // fpec_ctrl

// >>> hw/fpec_op_timer.sv
// ****************************************************************
// one-shot down counter that times a write or erase
// ****************************************************************
module fpec_op_timer #(
  parameter int CNT_W = 21
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,               // load pulse
  input wire logic [CNT_W-1:0] load_in,    // cycles to run
  output logic busy_out,                   // high while counting
  output logic done_out                    // pulse on last cycle
);
  logic [CNT_W-1:0] cnt_reg;  // remaining cycles

  // count down from the loaded length
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= '0;
    end else if (start_in) begin
      cnt_reg <= load_in;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign busy_out = (cnt_reg != '0);
  assign done_out = (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule // fpec_op_timer

// >>> hw/fpec_pkg.sv
package fpec_pkg;
  // ****************************************************************
  // register map (byte addresses on apb)
  // ****************************************************************
  localparam logic [7:0] FPEC_ADDR_CTRL = 8'h00;   // program_store_control
  localparam logic [7:0] FPEC_ADDR_BANK = 8'h04;   // bank_select_reg
  localparam logic [7:0] FPEC_ADDR_STAT = 8'h08;   // nvm_status_reg
  localparam logic [7:0] FPEC_ADDR_NVM_WRITE_ENABLE = 8'h0C;   // nvm write enable register
  // control field positions
  localparam int FPEC_CTRL_STORE_WRITE_ENABLE_BIT = 0;   // store_write_enable
  localparam int FPEC_CTRL_STORE_ERASE_ENABLE_BIT = 1;   // store_erase_enable
  localparam int FPEC_CTRL_SCRATCHPAD_ACCESS_ENABLE_BIT = 2;   // scratchpad_access_enable
  localparam int FPEC_BANK_LSB = 4;        // upper_bank_select position
  localparam int FPEC_NVM_WRITE_ENABLE_BIT = 0;        // nvm_write_enable
  localparam int FPEC_STAT_BUSY_BIT = 0;   // nvm_busy_flag
  // reset values
  localparam logic [1:0] FPEC_BANK_RESET = 2'h1;
  // ****************************************************************
  // memory geometry
  // ****************************************************************
  localparam int FPEC_ADDR_W = 17;                 // flash byte address width
  localparam int FPEC_MAIN_BYTES = 131072;         // main array (128 kB option)
  localparam int FPEC_PAGE_BITS = 10;              // 1024-byte pages
  localparam int FPEC_SCR_BYTES = 256;             // scratchpad area
  localparam int FPEC_SCR_SECT_BITS = 7;           // 128-byte sectors
  localparam logic [15:0] FPEC_BOTH_SECT_ADDR = 16'h0400;
  localparam logic [7:0] FPEC_ERASED = 8'hFF;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int FPEC_CLK_MHZ = 125;
  localparam int FPEC_WRITE_US = 50;               // byte write time
  localparam int FPEC_ERASE_MS = 12;               // page erase time
  localparam int FPEC_WRITE_CYC = FPEC_WRITE_US * FPEC_CLK_MHZ;
  localparam int FPEC_ERASE_CYC = FPEC_ERASE_MS * 1000 * FPEC_CLK_MHZ;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {FPEC_OP_IDLE, FPEC_OP_WRITE, FPEC_OP_ERASE} fpec_op_t;
  // external-data move request from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fpec_xreq_t;
  // code-space read request (fetch or code_memory_read)
  typedef struct packed {
    logic valid;
    logic is_fetch;
    logic cached;
    logic [15:0] addr;
  } fpec_creq_t;
endpackage : fpec_pkg

// >>> verification/fpec_asserts.sv
// ****************************************
// port checker for the flash sequencer
// ****************************************
module fpec_asserts #(
  parameter int WRITE_CYC = 10,
  parameter int ERASE_CYC = 40
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire fpec_pkg::fpec_xreq_t xreq_in,
  input wire logic external_data_ram_we_out,
  input wire logic external_data_ram_re_out,
  input wire logic [15:0] external_data_ram_addr_out,
  input wire logic [7:0] external_data_ram_wdata_out,
  input wire fpec_pkg::fpec_creq_t creq_in,
  input wire logic crvalid_out,
  input wire logic stall_out,
  input wire logic irq_pending_in,
  input wire logic irq_cached_in,
  input wire logic exec_cached_in,
  input wire logic irq_allow_out,
  input wire logic nvm_busy_flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ctl_reg; // shadow of control bits
  logic wen_reg; // shadow of nvm write enable
  logic ers_reg; // running op is an erase
  int cnt_reg; // cycles busy so far
  logic acc; // apb write completing
  logic mw; // data-move write
  logic go; // operation launch
  assign acc = psel_in & penable_in & pwrite_in;
  assign mw = xreq_in.valid & xreq_in.write;
  assign go = mw & ctl_reg[0] & wen_reg & !nvm_busy_flag_out;
  // shadows follow completed apb writes
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_reg <= 3'h0;
      wen_reg <= 1'b0;
    end else if (acc && paddr_in == fpec_pkg::FPEC_ADDR_CTRL) begin
      ctl_reg <= pwdata_in[2:0];
    end else if (acc && paddr_in == fpec_pkg::FPEC_ADDR_NVM_WRITE_ENABLE) begin
      wen_reg <= pwdata_in[0];
    end
  end
  // busy length and kind of operation
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= 0;
      ers_reg <= 1'b0;
    end else begin
      cnt_reg <= nvm_busy_flag_out ? cnt_reg + 1 : 0;
      if (go) begin
        ers_reg <= ctl_reg[1];
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_ram_wr;
    mw && !ctl_reg[0] |=> external_data_ram_we_out && external_data_ram_addr_out == $past(xreq_in.addr)
      && external_data_ram_wdata_out == $past(xreq_in.wdata);
  endproperty
  a_ram_wr: assert property (p_ram_wr) else $error("data ram write lost");
  property p_nvm_wr;
    mw && ctl_reg[0] |=> !external_data_ram_we_out;
  endproperty
  a_nvm_wr: assert property (p_nvm_wr) else $error("flash write reached ram");
  property p_rd;
    xreq_in.valid && !xreq_in.write |=> external_data_ram_re_out && !external_data_ram_we_out;
  endproperty
  a_rd: assert property (p_rd) else $error("data read not sent to ram");
  property p_go;
    go |=> nvm_busy_flag_out;
  endproperty
  a_go: assert property (p_go) else $error("busy not raised");
  property p_len;
    $fell(nvm_busy_flag_out) |-> cnt_reg == (ers_reg ? ERASE_CYC : WRITE_CYC);
  endproperty
  a_len: assert property (p_len) else $error("operation length wrong");
  property p_stall;
    creq_in.valid && !creq_in.cached && nvm_busy_flag_out |-> stall_out;
  endproperty
  a_stall: assert property (p_stall) else $error("fetch not stalled");
  property p_crv;
    creq_in.valid && !stall_out |=> crvalid_out;
  endproperty
  a_crv: assert property (p_crv) else $error("code read not answered");
  property p_irq_hit;
    irq_pending_in && irq_cached_in && exec_cached_in |-> irq_allow_out;
  endproperty
  a_irq_hit: assert property (p_irq_hit) else $error("cached irq blocked");
  property p_irq_wait;
    nvm_busy_flag_out && !(irq_cached_in && exec_cached_in) |-> !irq_allow_out;
  endproperty
  a_irq_wait: assert property (p_irq_wait) else $error("irq not held");
  property p_irq_free;
    $fell(nvm_busy_flag_out) && irq_pending_in |-> irq_allow_out;
  endproperty
  a_irq_free: assert property (p_irq_free) else $error("irq not released");
endmodule // fpec_asserts

bind fpec_ctrl fpec_asserts #(.WRITE_CYC(WRITE_CYC), .ERASE_CYC(ERASE_CYC)) fpec_asserts_inst (
  .clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .xreq_in,
  .external_data_ram_we_out, .external_data_ram_re_out, .external_data_ram_addr_out, .external_data_ram_wdata_out, .creq_in, .crvalid_out,
  .stall_out, .irq_pending_in, .irq_cached_in, .exec_cached_in, .irq_allow_out,
  .nvm_busy_flag_out);

// >>> verification/fpec_core_model.sv
// ****************************************
// core model: data moves and code reads
// ****************************************
module fpec_core_model (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic crvalid_in,
  input wire logic [7:0] crdata_in,
  output fpec_pkg::fpec_xreq_t xreq_out,
  output fpec_pkg::fpec_creq_t creq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    xreq_out = '0;
    creq_out = '0;
  end
  // erase, write or read by data move
  task automatic move(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_in);
    xreq_out <= {1'b1, w, a, v};
    @(posedge clk_in);
    // released fields carry inverted junk
    xreq_out <= {1'b0, ~w, ~a, ~v};
    #1;
  endtask
  // code read held while stalled, st counts stalled cycles
  task automatic cread(input logic f, input logic c, input logic [15:0] a,
    output logic [7:0] v, output int st);
    logic s;
    st = 0;
    @(posedge clk_in);
    creq_out <= {1'b1, f, c, a};
    do begin
      @(negedge clk_in);
      s = stall_in;
      if (s) st++;
      @(posedge clk_in);
    end while (s);
    creq_out <= {1'b0, ~f, ~c, ~a};
    #1;
    v = (crvalid_in === 1'b1) ? crdata_in : 8'hXX;
  endtask
endmodule // fpec_core_model

// >>> verification/tb_flash_program_erase_ctrl.sv
// ****************************************
// bench for the flash sequencer
// ****************************************
module tb_flash_program_erase_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WCYC = 10; // shortened byte write
  localparam int ECYC = 40; // shortened page erase
  localparam logic [7:0] CT = fpec_pkg::FPEC_ADDR_CTRL;
  localparam logic [7:0] BK = fpec_pkg::FPEC_ADDR_BANK;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic irq_p = 1'b0, irq_c = 1'b0, exec_c = 1'b0;
  logic pready_out, pslverr_out, external_data_ram_we_out, external_data_ram_re_out, crvalid_out, stall_out;
  logic irq_allow_out, busy;
  logic [15:0] external_data_ram_addr_out;
  logic [7:0] external_data_ram_wdata_out, crdata_out, d;
  fpec_pkg::fpec_xreq_t xreq;
  fpec_pkg::fpec_creq_t creq;
  int n_mismatch = 0, compares = 0, cyc = 0, st, ctl = 0, bank = 1;
  int seed = 32'h7912;
  int mem [int]; // reference flash bytes
  always #4 clk_in = ~clk_in;
  fpec_ctrl #(.WRITE_CYC(WCYC), .ERASE_CYC(ECYC)) fpec_ctrl_inst (.clk_in, .rst_b_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .xreq_in(xreq), .external_data_ram_we_out, .external_data_ram_re_out, .external_data_ram_addr_out,
    .external_data_ram_wdata_out, .creq_in(creq), .crdata_out, .crvalid_out, .stall_out,
    .irq_pending_in(irq_p), .irq_cached_in(irq_c), .exec_cached_in(exec_c),
    .irq_allow_out, .nvm_busy_flag_out(busy));
  fpec_core_model core_inst (.clk_in, .stall_in(stall_out), .crvalid_in(crvalid_out),
    .crdata_in(crdata_out), .xreq_out(xreq), .creq_out(creq));
  // model address: scratchpad, bank window or plain
  function automatic int fk(input logic [15:0] a, input bit s);
    if (s && ctl[2] && a < 16'h100) return 32'h20000 + a;
    return a[15] ? {bank[1:0], a[14:0]} : a;
  endfunction
  function automatic int rd(input int k);
    return mem.exists(k) ? mem[k] : -1;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] wd, ex,
    input bit er);
    @(posedge clk_in);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, wd};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    if (!w) chk("prdata", ex, prdata_out);
    chk("pslverr", er, pslverr_out);
    {psel_in, penable_in} <= 2'b00;
    if (w && a == CT) ctl = wd;
    if (w && a == BK) bank = wd[5:4];
  endtask
  // busy span with random interrupt inputs
  task automatic op(input int n);
    for (int i = 0; i < n; i++) begin
      chk("busy", 1, busy);
      chk("irq_allow", irq_p & irq_c & exec_c, irq_allow_out);
      @(posedge clk_in);
      // irq lines only pend, no move comes from a handler
      {irq_p, irq_c, exec_c} <= 3'($random(seed));
      #1;
    end
    chk("busy", 0, busy);
    chk("irq_allow", irq_p, irq_allow_out);
  endtask
  // flash write or erase, model first
  task automatic fw(input logic [15:0] a, input logic [7:0] v, input bit e);
    int k;
    int n;
    k = fk(a, 1'b1);
    n = k >= 32'h20000 ? 128 : 1024;
    if (e && ctl[2] && a == 16'h0400) begin
      k = 32'h20000;
      n = 256;
    end
    for (int i = 0; i < (e ? n : 1); i++) mem[e ? (k & -n) + i : k] = e ? 8'hFF : rd(k) & v;
    core_inst.move(1'b1, a, v);
    op(e ? ECYC : WCYC);
  endtask
  task automatic cr(input logic f, input logic [15:0] a);
    core_inst.cread(f, 1'b0, a, d, st);
    chk("crdata", rd(fk(a, !f)), d);
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 5000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // bank stays legal, addresses below reserved area
  initial begin
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    apb(0, BK, 0, 32'h10, 0);
    apb(0, fpec_pkg::FPEC_ADDR_STAT, 0, 0, 0);
    apb(1, 8'h40, 32'hFFFFFFFF, 0, 1);
    apb(0, CT, 0, 0, 0);
    d = 8'($random(seed));
    core_inst.move(1'b1, {8'h12, d}, d);
    chk("external_data_ram_we", 1, external_data_ram_we_out);
    chk("external_data_ram_addr", {8'h12, d}, external_data_ram_addr_out);
    chk("external_data_ram_wdata", d, external_data_ram_wdata_out);
    apb(1, fpec_pkg::FPEC_ADDR_NVM_WRITE_ENABLE, 1, 0, 0);
    apb(1, CT, 3, 0, 0);
    fork
      fw(16'h0123, 8'h00, 1'b1);
      begin
        repeat (4) @(posedge clk_in);
        core_inst.cread(1'b1, 1'b1, 16'h0200, d, st);
        chk("stall", 0, st);
        core_inst.cread(1'b1, 1'b0, 16'h0200, d, st);
        chk("stall", 1, st > 20);
        chk("crdata", 8'hFF, d);
      end
    join
    apb(1, CT, 1, 0, 0);
    fw(16'h0123, 8'($random(seed)), 0);
    fw(16'h0123, 8'($random(seed)), 0);
    cr(0, 16'h0123);
    apb(0, CT, 0, 1, 0);
    core_inst.move(1'b0, 16'h0123, 8'h00);
    chk("external_data_ram_re", 1, external_data_ram_re_out);
    apb(1, CT, 7, 0, 0);
    fw(16'h0400, 8'h00, 1'b1);
    apb(1, CT, 5, 0, 0);
    fw(16'h0085, 8'($random(seed)), 0);
    cr(0, 16'h0085);
    cr(1, 16'h0085);
    apb(1, CT, 7, 0, 0);
    fw(16'h0085, 8'h00, 1'b1);
    cr(0, 16'h0085);
    apb(1, CT, 1, 0, 0);
    cr(0, 16'h0085);
    apb(1, CT, 3, 0, 0);
    apb(1, BK, 32'h20, 0, 0);
    fw(16'h8000, 8'h00, 1'b1);
    apb(1, BK, 32'h10, 0, 0);
    fw(16'h8000, 8'h00, 1'b1);
    apb(1, CT, 1, 0, 0);
    fw(16'h8004, 8'h3C, 0);
    apb(1, BK, 32'h20, 0, 0);
    cr(0, 16'h8004);
    apb(1, fpec_pkg::FPEC_ADDR_NVM_WRITE_ENABLE, 0, 0, 0);
    core_inst.move(1'b1, 16'h8004, 8'h00);
    chk("busy", 0, busy);
    chk("external_data_ram_we", 0, external_data_ram_we_out);
    cr(0, 16'h8004);
    complete_run();
  end
endmodule // tb_flash_program_erase_ctrl
